// ### hdl/dic_pkg.sv
// Constants shared by the digital input channel conditioner.
// Assumes a single 100 MHz module clock and a plain register port.
package dic_pkg;
	localparam int NCH           = 7;
	localparam int DLY_W         = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int FRAME_US      = 6500;
	localparam int FRAME_CYC     = FRAME_US * 1000 / CLK_PERIOD_NS;

	// Register offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_FAULT_EN = 8'h04;
	localparam logic [7:0] OFS_SIG_TYPE = 8'h08;
	localparam logic [7:0] OFS_SIM_MODE = 8'h0c;
	localparam logic [7:0] OFS_SIM_VAL  = 8'h10;
	localparam logic [7:0] OFS_INVERT   = 8'h14;
	localparam logic [7:0] OFS_ERR_MODE = 8'h18;
	localparam logic [7:0] OFS_SUBST    = 8'h1c;
	localparam logic [7:0] OFS_DELAY0   = 8'h20;
	localparam logic [7:0] OFS_STATUS   = 8'h40;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h44;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
	localparam logic [7:0] OFS_FRAME    = 8'h4c;

	// Field positions
	localparam int CTRL_ACTIVE_BIT = 0;
	localparam int SIM_INV_LSB     = 8;
	localparam int DLY_ON_LSB      = 0;
	localparam int DLY_OFF_LSB     = 16;
	localparam int STATUS_VAL_LSB  = 16;
	localparam int ERR_W           = 2;

	// Reset values
	localparam logic       RST_ACTIVE   = 1'b1;
	localparam logic [6:0] RST_FAULT_EN = 7'h7f;

	// Error strategy per channel
	typedef enum logic [1:0] {ERR_PASS, ERR_SUBST, ERR_HOLD, ERR_RSVD} dic_err_t;
endpackage : dic_pkg

// ### hdl/dic_delay.sv
// On/off delay of one channel, counted in millisecond ticks.
// Assumes din is already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module dic_delay #(
	parameter int MSW = 16
) (
	input  wire logic           clock,
	input  wire logic           rst_n,
	input  wire logic           clk_en,
	input  wire logic           tick_ms,
	input  wire logic           din,
	input  wire logic [MSW-1:0] on_ms,
	input  wire logic [MSW-1:0] off_ms,
	output logic                dout
);
	import dic_pkg::*;

	typedef struct packed {
		logic           out;
		logic [MSW-1:0] cnt;
	} dic_dly_state_t;

	dic_dly_state_t r_reg;
	dic_dly_state_t r_next;
	logic [MSW-1:0] lim;
	logic [MSW-1:0] cnt_inc;

	// A change must persist until the count reaches the limit; the first
	// tick may come early, so the delay is lim-1 to lim milliseconds
	always_comb
	begin
		r_next  = r_reg;
		lim     = din ? on_ms : off_ms;
		cnt_inc = r_reg.cnt + {{(MSW-1){1'b0}}, 1'b1};
		if (clk_en)
		begin
			if (din == r_reg.out)
				r_next.cnt = '0;
			else if (lim == '0 || (tick_ms && cnt_inc >= lim))
			begin
				r_next.out = din;
				r_next.cnt = '0;
			end
			else if (tick_ms)
				r_next.cnt = cnt_inc;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign dout = r_reg.out;

	default clocking dcb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_fall_wait;
		clk_en && r_reg.out && !din && off_ms != '0 && !tick_ms;
	endsequence

	a_rise_cause: assert property ($rose(dout) |-> $past(din) && ($past(on_ms) == '0 || $past(tick_ms)))
		else $error("output rose without input high and delay expiry");
	a_fall_cause: assert property ($fell(dout) |-> !$past(din) && ($past(off_ms) == '0 || $past(tick_ms)))
		else $error("output fell without input low and delay expiry");
	a_hold_high: assert property (s_fall_wait |=> r_reg.out)
		else $error("output dropped before off delay elapsed");
endmodule : dic_delay
`default_nettype wire

// ### hdl/dic_top.sv
// Seven-channel digital input conditioner with register port and frame output.
// Assumes field and fault pins are asynchronous; register port is synchronous.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each channel detects open or shorted wiring; per-channel enable switches detection off.
// - A detected fault sets the channel fault bit and invokes the error strategy.
// - Active 24 V or 5 V input selection refused while fault detection is enabled.
// - Normal mode forwards the live conditioned input state.
// - Simulation mode forwards a configured bit with configured validity status.
// - Pass strategy keeps forwarding the field value during a fault.
// - Substitute strategy forwards a configured bit, always flagged invalid.
// - Hold strategy forwards the last valid value from before the fault.
// - Inversion setting inverts the channel input before forwarding.
// - Rising change appears only after the on delay in milliseconds.
// - Falling change is held off for the off delay in milliseconds.
// - Channel active state follows the module-wide active setting only.
// - All channel states are sent every 6.5 ms while the module is active, regardless of polling.
// - Each channel reports a value bit then a fault bit, one meaning fault.
module dic_top #(
	parameter int TICK_CYCLES  = dic_pkg::TICK_CYC,
	parameter int FRAME_CYCLES = dic_pkg::FRAME_CYC
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic [dic_pkg::NCH-1:0] field_in,
	input  wire logic [dic_pkg::NCH-1:0] line_fault_in,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata,
	output logic [15:0]                frame_data,
	output logic                       frame_valid,
	output logic [dic_pkg::NCH-1:0]    chan_invalid,
	output logic [dic_pkg::NCH-1:0]    active_in_sel,
	output logic                       irq
);
	import dic_pkg::*;

	typedef struct packed {
		logic [NCH-1:0]            sync1_fld;
		logic [NCH-1:0]            sync2_fld;
		logic [NCH-1:0]            sync1_lf;
		logic [NCH-1:0]            sync2_lf;
		logic                      active;
		logic [NCH-1:0]            fault_en;
		logic [NCH-1:0]            sig_type;
		logic [NCH-1:0]            sim_mode;
		logic [NCH-1:0]            sim_val;
		logic [NCH-1:0]            sim_inv;
		logic [NCH-1:0]            invert;
		logic [NCH-1:0][ERR_W-1:0] err_mode;
		logic [NCH-1:0]            subst_val;
		logic [NCH-1:0][DLY_W-1:0] on_ms;
		logic [NCH-1:0][DLY_W-1:0] off_ms;
		logic [19:0]               tick_cnt;
		logic [19:0]               frame_cnt;
		logic [NCH-1:0]            last_valid;
		logic [NCH-1:0]            fault_prev;
		logic [NCH-1:0]            irq_stat;
		logic [NCH-1:0]            irq_mask;
		logic [15:0]               frame;
		logic                      frame_vld;
		logic [NCH-1:0]            frame_inv;
		logic [31:0]               rdata;
	} dic_top_state_t;

	dic_top_state_t r_reg;
	dic_top_state_t r_next;
	logic           tick_ms;
	logic           frame_due;
	logic [NCH-1:0] inv_in;
	logic [NCH-1:0] dly_out;
	logic [NCH-1:0] ch_fault;
	logic [NCH-1:0] ch_val;
	logic [NCH-1:0] ch_inv;
	logic [15:0]    frame_pack;

	// Bit position of a channel's value bit; the fault bit sits just above
	function automatic int frame_pos(input int ch);
		return (ch < 4) ? 8 + 2 * ch : 2 * (ch - 4);
	endfunction : frame_pos

	// True when the address selects the delay register of channel ch
	function automatic logic dly_hit(input logic [7:0] addr, input int ch);
		return addr == OFS_DELAY0 + 8'(4 * ch);
	endfunction : dly_hit

	// Millisecond tick and frame period both come from the module clock
	assign tick_ms   = clk_en && r_reg.tick_cnt == 20'(TICK_CYCLES - 1);
	assign frame_due = clk_en && r_reg.frame_cnt == 20'(FRAME_CYCLES - 1);

	// Inversion precedes the delays so that delays act on the logical state
	assign inv_in = r_reg.sync2_fld ^ r_reg.invert;

	// Faults count only on channels with detection enabled in an active module
	assign ch_fault = r_reg.fault_en & r_reg.sync2_lf & {NCH{r_reg.active}};

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_dly
			dic_delay #(
				.MSW(DLY_W)
			) u_dly (
				.clock  (clock),
				.rst_n  (rst_n),
				.clk_en (clk_en),
				.tick_ms(tick_ms),
				.din    (inv_in[gi]),
				.on_ms  (r_reg.on_ms[gi]),
				.off_ms (r_reg.off_ms[gi]),
				.dout   (dly_out[gi])
			);
		end
	endgenerate

	// Mode and error strategy selection after the delays
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			ch_val[i] = dly_out[i];
			ch_inv[i] = 1'b0;
			if (!r_reg.active)
			begin
				ch_val[i] = 1'b0;
			end
			else if (r_reg.sim_mode[i])
			begin
				ch_val[i] = r_reg.sim_val[i];
				ch_inv[i] = r_reg.sim_inv[i];
			end
			else if (ch_fault[i])
			begin
				case (dic_err_t'(r_reg.err_mode[i]))
					ERR_SUBST:
					begin
						ch_val[i] = r_reg.subst_val[i];
						ch_inv[i] = 1'b1;
					end
					ERR_HOLD: ch_val[i] = r_reg.last_valid[i];
					default:  ch_val[i] = dly_out[i];
				endcase
			end
		end
	end

	// Telegram image: byte one holds channels 5..7, byte two channels 1..4
	always_comb
	begin
		frame_pack = '0;
		for (int i = 0; i < NCH; i++)
		begin
			frame_pack[frame_pos(i)]     = ch_val[i];
			frame_pack[frame_pos(i) + 1] = ch_fault[i];
		end
	end

	// Whole next state; clk_en low freezes everything
	always_comb
	begin
		r_next = r_reg;
		if (clk_en)
		begin
			// Two stages before any logic looks at the pins
			r_next.sync1_fld = field_in;
			r_next.sync2_fld = r_reg.sync1_fld;
			r_next.sync1_lf  = line_fault_in;
			r_next.sync2_lf  = r_reg.sync1_lf;
			r_next.tick_cnt  = tick_ms ? '0 : r_reg.tick_cnt + 20'h00001;
			r_next.frame_cnt = frame_due ? '0 : r_reg.frame_cnt + 20'h00001;
			// Last good value is frozen the moment a fault appears
			for (int i = 0; i < NCH; i++)
				if (!ch_fault[i])
					r_next.last_valid[i] = dly_out[i];
			// Periodic send, independent of any reads
			r_next.frame_vld = frame_due && r_reg.active;
			if (frame_due && r_reg.active)
			begin
				r_next.frame     = frame_pack;
				r_next.frame_inv = ch_inv;
			end
			// Register writes
			if (reg_wr)
			begin
				case (reg_addr)
					OFS_CTRL:     r_next.active = reg_wdata[CTRL_ACTIVE_BIT];
					// Detection cannot be enabled under an active input type
					OFS_FAULT_EN: r_next.fault_en = reg_wdata[NCH-1:0] & ~r_reg.sig_type;
					// Active input type only where detection is off
					OFS_SIG_TYPE: r_next.sig_type = reg_wdata[NCH-1:0] & ~r_reg.fault_en;
					OFS_SIM_MODE: r_next.sim_mode = reg_wdata[NCH-1:0];
					OFS_SIM_VAL:
					begin
						r_next.sim_val = reg_wdata[NCH-1:0];
						r_next.sim_inv = reg_wdata[SIM_INV_LSB +: NCH];
					end
					OFS_INVERT:   r_next.invert    = reg_wdata[NCH-1:0];
					OFS_ERR_MODE: r_next.err_mode  = reg_wdata[NCH*ERR_W-1:0];
					OFS_SUBST:    r_next.subst_val = reg_wdata[NCH-1:0];
					OFS_IRQ_MASK: r_next.irq_mask  = reg_wdata[NCH-1:0];
					default:
					begin
						for (int i = 0; i < NCH; i++)
							if (dly_hit(reg_addr, i))
							begin
								r_next.on_ms[i]  = reg_wdata[DLY_ON_LSB +: DLY_W];
								r_next.off_ms[i] = reg_wdata[DLY_OFF_LSB +: DLY_W];
							end
					end
				endcase
			end
			// Fault onset is the event; a new onset beats a clearing write
			r_next.fault_prev = ch_fault;
			r_next.irq_stat   = r_reg.irq_stat;
			if (reg_wr && reg_addr == OFS_IRQ_STAT)
				r_next.irq_stat = r_reg.irq_stat & ~reg_wdata[NCH-1:0];
			r_next.irq_stat = r_next.irq_stat | (ch_fault & ~r_reg.fault_prev);
			// Read data appears in the cycle after the strobe only
			r_next.rdata = '0;
			if (reg_rd)
			begin
				case (reg_addr)
					OFS_CTRL:     r_next.rdata[CTRL_ACTIVE_BIT] = r_reg.active;
					OFS_FAULT_EN: r_next.rdata[NCH-1:0] = r_reg.fault_en;
					OFS_SIG_TYPE: r_next.rdata[NCH-1:0] = r_reg.sig_type;
					OFS_SIM_MODE: r_next.rdata[NCH-1:0] = r_reg.sim_mode;
					OFS_SIM_VAL:
					begin
						r_next.rdata[NCH-1:0]            = r_reg.sim_val;
						r_next.rdata[SIM_INV_LSB +: NCH] = r_reg.sim_inv;
					end
					OFS_INVERT:   r_next.rdata[NCH-1:0]       = r_reg.invert;
					OFS_ERR_MODE: r_next.rdata[NCH*ERR_W-1:0] = r_reg.err_mode;
					OFS_SUBST:    r_next.rdata[NCH-1:0]       = r_reg.subst_val;
					OFS_STATUS:
					begin
						r_next.rdata[NCH-1:0]               = ch_fault;
						r_next.rdata[STATUS_VAL_LSB +: NCH] = ch_val;
					end
					OFS_IRQ_STAT: r_next.rdata[NCH-1:0] = r_reg.irq_stat;
					OFS_IRQ_MASK: r_next.rdata[NCH-1:0] = r_reg.irq_mask;
					OFS_FRAME:    r_next.rdata[15:0]    = r_reg.frame;
					default:
					begin
						for (int i = 0; i < NCH; i++)
							if (dly_hit(reg_addr, i))
							begin
								r_next.rdata[DLY_ON_LSB +: DLY_W]  = r_reg.on_ms[i];
								r_next.rdata[DLY_OFF_LSB +: DLY_W] = r_reg.off_ms[i];
							end
					end
				endcase
			end
		end
	end

	// Synchronous reset to constants only
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			r_reg          <= '0;
			r_reg.active   <= RST_ACTIVE;
			r_reg.fault_en <= RST_FAULT_EN;
		end
		else
			r_reg <= r_next;
	end

	assign reg_rdata     = r_reg.rdata;
	assign frame_data    = r_reg.frame;
	assign frame_valid   = r_reg.frame_vld;
	assign chan_invalid  = r_reg.frame_inv;
	assign active_in_sel = r_reg.sig_type;
	assign irq           = |(r_reg.irq_stat & r_reg.irq_mask); // Level, not a pulse

	default clocking tcb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_hold0;
		clk_en && r_reg.active && !r_reg.sim_mode[0] && ch_fault[0] && r_reg.err_mode[0] == ERR_HOLD;
	endsequence

	// A pulse held over by a low clock enable is not a new frame
	sequence s_sel_sent;
		frame_valid && $past(clk_en);
	endsequence

	a_sig_refused: assert property (clk_en && reg_wr && reg_addr == OFS_SIG_TYPE && r_reg.fault_en[0] |=> !r_reg.sig_type[0])
		else $error("active input type accepted with detection on");
	a_fault_report: assert property (s_sel_sent |-> frame_data[9] == $past(ch_fault[0]))
		else $error("fault bit of channel 1 wrong in frame");
	a_sim_forward: assert property (s_sel_sent and $past(r_reg.sim_mode[0] && r_reg.active) |-> frame_data[8] == $past(r_reg.sim_val[0]) && chan_invalid[0] == $past(r_reg.sim_inv[0]))
		else $error("simulated value or status not forwarded");
	a_subst_invalid: assert property (s_sel_sent and $past(!r_reg.sim_mode[0] && ch_fault[0] && r_reg.err_mode[0] == ERR_SUBST) |-> chan_invalid[0] && frame_data[8] == $past(r_reg.subst_val[0]))
		else $error("substitute value not forwarded as invalid");
	a_pass_value: assert property (s_sel_sent and $past(!r_reg.sim_mode[0] && ch_fault[0] && r_reg.err_mode[0] == ERR_PASS) |-> frame_data[8] == $past(dly_out[0]) && !chan_invalid[0])
		else $error("pass strategy altered field value");
	a_hold_value: assert property (s_hold0 ##1 s_hold0 |-> ch_val[0] == $past(ch_val[0]))
		else $error("held value changed during fault");
	a_frame_period: assert property (s_sel_sent |-> $past(r_reg.frame_cnt) == 20'(FRAME_CYCLES - 1))
		else $error("frame sent off period");
	a_frame_gap: assert property (frame_valid && clk_en |=> !frame_valid [*8])
		else $error("frames too close together");
	a_irq_onset: assert property (clk_en && ch_fault[0] && !r_reg.fault_prev[0] |=> r_reg.irq_stat[0] ##0 irq == (r_reg.irq_mask[0] || |(r_reg.irq_stat[6:1] & r_reg.irq_mask[6:1])))
		else $error("fault onset not latched");
endmodule : dic_top
`default_nettype wire

// ### sim/dic_collector.sv
// Collecting-unit model: takes each frame image the conditioner sends.
// Assumes frames arrive as one-cycle frame_valid pulses on clock.
`timescale 1ns/1ps
`default_nettype none
module dic_collector #(
	parameter int FRAME_CYCLES = 40
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        frame_valid,
	input  wire logic [15:0] frame_data,
	output var  int          frame_cnt,
	output var  int          bad_cnt
);
	int gap;

	// Inactive spans still keep the frame grid, so any gap is a whole multiple
	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			frame_cnt <= 0;
			bad_cnt   <= 0;
			gap       <= 1;
		end
		else if (frame_valid === 1'b1)
		begin
			frame_cnt <= frame_cnt + 1;
			gap       <= 1;
			if (frame_cnt > 0 && gap % FRAME_CYCLES != 0)
				bad_cnt <= bad_cnt + 1;
			if (frame_data[7:6] !== 2'b00)
				bad_cnt <= bad_cnt + 1;
		end
		else
			gap <= gap + 1;
	end
endmodule : dic_collector
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the seven-channel input conditioner.
// Assumes short tick and frame parameters; collector model watches frames.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dic_pkg::*;
	localparam int TK = 4;
	localparam int FR = 40;
	logic           clock, rst_n, clk_en, reg_wr, reg_rd, irq, frame_valid;
	logic [NCH-1:0] field_in, line_fault_in, chan_invalid, active_in_sel;
	logic [7:0]     reg_addr;
	logic [31:0]    reg_wdata, reg_rdata, d;
	logic [15:0]    frame_data, seed;
	int             mismatches, check_count, frame_cnt, bad_cnt, n;

	dic_top #(.TICK_CYCLES(TK), .FRAME_CYCLES(FR)) i_dut (.clock(clock), .rst_n(rst_n),
		.clk_en(clk_en), .field_in(field_in), .line_fault_in(line_fault_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_data(frame_data), .frame_valid(frame_valid),
		.chan_invalid(chan_invalid), .active_in_sel(active_in_sel), .irq(irq));
	dic_collector #(.FRAME_CYCLES(FR)) i_col (.clock(clock), .rst_n(rst_n),
		.frame_valid(frame_valid), .frame_data(frame_data), .frame_cnt(frame_cnt),
		.bad_cnt(bad_cnt));

	// Free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic settle(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask : settle

	// Register writes and reads: one-cycle strobes launched after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	// Bounded wait for the next frame pulse, then confirm it lasts one cycle
	task automatic wait_frame;
		int c;
		c = 0;
		do
		begin
			settle(1);
			c++;
		end while (frame_valid !== 1'b1 && c < 2 * FR);
		chk("frame_seen", frame_valid, 1'b1);
		settle(1);
		chk("frame_pulse", frame_valid, 1'b0);
	endtask : wait_frame

	function automatic logic [15:0] fimg(input logic [6:0] v, input logic [6:0] f);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < NCH; i++)
			if (i < 4)
				r[8+2*i +: 2] = {f[i], v[i]};
			else
				r[2*i-8 +: 2] = {f[i], v[i]};
		return r;
	endfunction : fimg

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Hang guard, far beyond the roughly one thousand cycles the sequence needs
	initial
	begin
		#500000;
		mismatches++;
		stop_test();
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, field_in, line_fault_in} = '0;
		clk_en = 1'b1;
		seed   = 16'h0837;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		// Strobes are ignored while the clock enable is low
		@(posedge clock);
		clk_en <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		clk_en <= 1'b1;
		rd(OFS_CTRL, d);
		chk("ctrl_rst", d, 32'h1);
		rd(OFS_FAULT_EN, d);
		chk("fault_en_rst", d, 32'h7f);
		rd(8'h80, d);
		chk("unmapped", d, 32'h0);
		// Active input type only where detection is off
		wr(OFS_SIG_TYPE, 32'h7f);
		rd(OFS_SIG_TYPE, d);
		chk("sig_refused", d, 32'h0);
		wr(OFS_FAULT_EN, 32'h0f);
		wr(OFS_SIG_TYPE, 32'h7f);
		rd(OFS_SIG_TYPE, d);
		chk("sig_partial", d, 32'h70);
		chk("active_sel", active_in_sel, 7'h70);
		wr(OFS_FAULT_EN, 32'h7f);
		rd(OFS_FAULT_EN, d);
		chk("fault_en_blk", d, 32'h0f);
		wr(OFS_SIG_TYPE, 32'h0);
		wr(OFS_FAULT_EN, 32'h7f);
		for (int i = 0; i < NCH; i++)
			wr(OFS_DELAY0 + 8'(4 * i), 32'h0);
		// Random field values and inversion in normal mode
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			wr(OFS_INVERT, {25'h0, seed[6:0]});
			@(posedge clock);
			field_in <= seed[13:7];
			settle(8);
			rd(OFS_STATUS, d);
			chk("live_val", d[22:16], seed[13:7] ^ seed[6:0]);
			wait_frame();
			chk("frame", frame_data, fimg(seed[13:7] ^ seed[6:0], 7'h0));
		end
		wr(OFS_INVERT, 32'h0);
		// Every error strategy code on channel one, input falling during a fault
		wr(OFS_SUBST, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			wr(OFS_ERR_MODE, 32'(m));
			@(posedge clock);
			field_in <= 7'h01;
			settle(8);
			@(posedge clock);
			line_fault_in <= 7'h01;
			settle(8);
			@(posedge clock);
			field_in <= 7'h00;
			settle(8);
			rd(OFS_STATUS, d);
			chk("fault_val", d[16], m == 1 || m == 2);
			chk("fault_bit", d[0], 1'b1);
			wait_frame();
			chk("invalid", chan_invalid[0], m == 1);
			chk("irq_on", irq, 1'b1);
			@(posedge clock);
			line_fault_in <= 7'h00;
			wr(OFS_IRQ_STAT, 32'h1);
			settle(4);
			chk("irq_clr", irq, 1'b0);
		end
		// Detection switched off, then masking and clearing of the event
		wr(OFS_FAULT_EN, 32'h7e);
		@(posedge clock);
		line_fault_in <= 7'h01;
		settle(6);
		rd(OFS_STATUS, d);
		chk("fault_off", d[0], 1'b0);
		chk("irq_off", irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_FAULT_EN, 32'h7f);
		settle(4);
		chk("irq_masked", irq, 1'b0);
		rd(OFS_IRQ_STAT, d);
		chk("irq_stat", d, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		settle(1);
		chk("irq_unmask", irq, 1'b1);
		wr(OFS_IRQ_STAT, 32'h1);
		settle(1);
		chk("irq_w1c", irq, 1'b0);
		@(posedge clock);
		line_fault_in <= 7'h00;
		// Simulation values with random validity
		wr(OFS_SIM_MODE, 32'h7f);
		for (int k = 0; k < 3; k++)
		begin
			seed = lfsr(seed);
			wr(OFS_SIM_VAL, {17'h0, seed[14:8], 1'b0, seed[6:0]});
			wait_frame();
			wait_frame();
			chk("sim_frame", frame_data, fimg(seed[6:0], 7'h0));
			chk("sim_status", chan_invalid, seed[14:8]);
		end
		wr(OFS_SIM_MODE, 32'h0);
		// Three-tick delays: short high and low pulses are both swallowed
		wr(OFS_DELAY0, {16'd3, 16'd3});
		settle(20);
		@(posedge clock);
		field_in <= 7'h01;
		repeat (4) @(posedge clock);
		field_in <= 7'h00;
		repeat (6)
		begin
			rd(OFS_STATUS, d);
			chk("on_dly", d[16], 1'b0);
		end
		@(posedge clock);
		field_in <= 7'h01;
		settle(20);
		rd(OFS_STATUS, d);
		chk("on_late", d[16], 1'b1);
		@(posedge clock);
		field_in <= 7'h00;
		repeat (4) @(posedge clock);
		field_in <= 7'h01;
		repeat (6)
		begin
			rd(OFS_STATUS, d);
			chk("off_dly", d[16], 1'b1);
		end
		// Module switched inactive: no values, no frames
		@(posedge clock);
		field_in <= 7'h7e;
		wr(OFS_CTRL, 32'h0);
		settle(8);
		n = frame_cnt;
		rd(OFS_STATUS, d);
		chk("inactive", d, 32'h0);
		settle(3 * FR);
		chk("no_frames", frame_cnt == n, 1'b1);
		wr(OFS_CTRL, 32'h1);
		wait_frame();
		wait_frame();
		chk("resume", frame_data, fimg(7'h7e, 7'h0));
		chk("spacing", bad_cnt, 32'h0);
		stop_test();
	end
endmodule : tb
`default_nettype wire
